// ===== qrs_port.sv
// Purpose: port logic of a separate-I/O four-word burst SRAM
// Assumes: memory clocks are pins sampled by clk_i; edges found after two flops
// Notes:   read words pass an 8-word FIFO before the output register
`timescale 1ns/1ns
`include "qrs_defs.svh"
module qrs_port import qrs_pkg::*; (
  // System clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  // Memory clocks and straps (pins)
  input  wire logic                     k_clk_i,
  input  wire logic                     k_clk_n_i,
  input  wire logic                     c_clk_i,
  input  wire logic                     c_clk_n_i,
  input  wire logic                     delay_loop_disable_n_i,
  // Request pins
  input  wire logic                     read_port_select_n_i,
  input  wire logic                     write_port_select_n_i,
  input  wire logic [`QRS_AW-1:0]       addr_i,
  input  wire logic [`QRS_DW-1:0]       wdata_i,
  input  wire logic [`QRS_NBYTE-1:0]    byte_write_select_n_i,
  // Read data and echo clocks
  output logic      [`QRS_DW-1:0]       rdata_o,
  output logic                          rdata_oe_o,
  output logic                          returned_strobe_o,
  output logic                          returned_strobe_n_o,
  // Status
  output logic                          lock_o,
  output logic                          zq_update_o
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int NS = 11;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [NS-1:0] s3_q;
  logic [`QRS_AW-1:0]    a1_q, a2_q;
  logic [`QRS_DW-1:0]    d1_q, d2_q;
  logic [`QRS_NBYTE-1:0] b1_q, b2_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      a1_q <= '0;
      a2_q <= '0;
      d1_q <= '0;
      d2_q <= '0;
      b1_q <= '1;
      b2_q <= '1;
    end else begin
      s1_q <= {4'h0, write_port_select_n_i, read_port_select_n_i, delay_loop_disable_n_i,
               c_clk_n_i, c_clk_i, k_clk_n_i, k_clk_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      a1_q <= addr_i;
      a2_q <= a1_q;
      d1_q <= wdata_i;
      d2_q <= d1_q;
      b1_q <= byte_write_select_n_i;
      b2_q <= b1_q;
    end
  end

  logic k_rise, kn_rise, c_rise, cn_rise;
  logic rps_n, wps_n, delay_loop_disable_n_n;
  // Edges taken from second and third stages only
  assign k_rise  = s2_q[0] & ~s3_q[0];
  assign kn_rise = s2_q[1] & ~s3_q[1];
  assign rps_n   = s2_q[5];
  assign wps_n   = s2_q[6];
  assign delay_loop_disable_n_n  = s2_q[4];

  // ****************************************************************
  // Strap capture and delay-loop lock
  // ****************************************************************
  logic strap_done_q;
  logic single_clk_q;
  logic [10:0] lock_cnt_q;
  logic [7:0]  idle_cnt_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_done_q <= 1'b0;
      single_clk_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      single_clk_q <= s2_q[2] & s2_q[3];
    end
  end

  // Lock counts K rises; a long gap in K restarts it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_cnt_q <= '0;
      idle_cnt_q <= '0;
      lock_o     <= 1'b0;
    end else begin
      if (k_rise) begin
        idle_cnt_q <= '0;
        if (lock_cnt_q != `QRS_LOCK_CYCLES) begin
          lock_cnt_q <= lock_cnt_q + 11'd1;
        end
      end else if (idle_cnt_q != 8'hFF) begin
        idle_cnt_q <= idle_cnt_q + 8'h01;
      end
      if (idle_cnt_q == 8'hFE) begin
        lock_cnt_q <= '0;
      end
      lock_o <= delay_loop_disable_n_n && (lock_cnt_q == `QRS_LOCK_CYCLES);
    end
  end

  // ****************************************************************
  // Impedance update tick
  // ****************************************************************
  logic [10:0] zq_cnt_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zq_cnt_q    <= '0;
      zq_update_o <= 1'b0;
    end else begin
      zq_update_o <= 1'b0;
      if (k_rise) begin
        if (zq_cnt_q == `QRS_ZQ_PERIOD - 11'd1) begin
          zq_cnt_q    <= '0;
          zq_update_o <= 1'b1;
        end else begin
          zq_cnt_q <= zq_cnt_q + 11'd1;
        end
      end
    end
  end

  // ****************************************************************
  // Arbitration on K rise
  // ****************************************************************
  last_op_type last_q;
  logic start_rd, start_wr;

  always_comb begin
    start_rd = 1'b0;
    start_wr = 1'b0;
    if (k_rise) begin
      unique case (last_q)
        LAST_READ:  start_wr = !wps_n;
        LAST_WRITE: start_rd = !rps_n;
        LAST_IDLE: begin
          start_rd = !rps_n;
          start_wr = rps_n && !wps_n;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_q <= LAST_IDLE;
    end else if (k_rise) begin
      last_q <= start_rd ? LAST_READ : (start_wr ? LAST_WRITE : LAST_IDLE);
    end
  end

  // ****************************************************************
  // Memory array and write burst
  // ****************************************************************
  logic [`QRS_DW-1:0] mem_q [2**`QRS_AW];
  logic [`QRS_AW-1:0] wa_q;
  logic [1:0]         wbeat_q;
  logic               wact_q;
  logic               wgo_q;
  logic               wtake;

  function automatic logic [`QRS_DW-1:0] merge(input logic [`QRS_DW-1:0] old,
                                               input logic [`QRS_DW-1:0] nw,
                                               input logic [`QRS_NBYTE-1:0] bsn);
    logic [`QRS_DW-1:0] r;
    r = old;
    for (int i = 0; i < `QRS_NBYTE; i++) begin
      if (!bsn[i]) begin
        r[i*`QRS_BYTEW +: `QRS_BYTEW] = nw[i*`QRS_BYTEW +: `QRS_BYTEW];
      end
    end
    return r;
  endfunction

  // Address still owed a word by the running write burst
  function automatic logic wr_pending(input logic [`QRS_AW-1:0] a,
                                      input logic [`QRS_AW-1:0] wa,
                                      input logic [1:0]         beat,
                                      input logic               act);
    return act && ((a - wa) <= `QRS_AW'(`QRS_BURST_LAST - beat));
  endfunction

  // First word waits for the K rise after the one that took the address
  assign wtake = wact_q && !start_wr && (k_rise || (kn_rise && wgo_q));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wact_q  <= 1'b0;
      wbeat_q <= '0;
      wa_q    <= '0;
      wgo_q   <= 1'b0;
    end else begin
      if (start_wr) begin
        wact_q  <= 1'b1;
        wbeat_q <= '0;
        wa_q    <= a2_q;
        wgo_q   <= 1'b0;
      end else if (wtake) begin
        wgo_q   <= 1'b1;
        wbeat_q <= wbeat_q + 2'd1;
        wa_q    <= wa_q + `QRS_AW'(1);
        if (wbeat_q == `QRS_BURST_LAST) begin
          wact_q <= 1'b0;
        end
      end
    end
  end

  // Words land immediately so a following read sees them
  always_ff @(posedge clk_i) begin
    if (wtake) begin
      mem_q[wa_q] <= merge(mem_q[wa_q], d2_q, b2_q);
    end
  end

  // ****************************************************************
  // Read burst: fetch into FIFO, drain on output edges
  // ****************************************************************
  logic [`QRS_AW-1:0] ra_q;
  logic [2:0]         rfetch_q;
  logic               f_in_ready, f_out_valid, pop;
  logic [`QRS_DW-1:0] f_out_data;
  logic               oclk_rise, oclk_n_rise;
  logic               rd_stall;
  logic [1:0]         skip_q;
  logic [3:0]         rq_cnt_q;

  // Fetch waits until a word still owed by a write has landed
  assign rd_stall = wr_pending(ra_q, wa_q, wbeat_q, wact_q);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ra_q     <= '0;
      rfetch_q <= '0;
    end else if (start_rd) begin
      ra_q     <= a2_q;
      rfetch_q <= 3'd4;
    end else if (rfetch_q != 3'd0 && f_in_ready && !rd_stall) begin
      ra_q     <= ra_q + `QRS_AW'(1);
      rfetch_q <= rfetch_q - 3'd1;
    end
  end

  qrs_fifo #(.WIDTH(`QRS_DW), .DEPTH(`QRS_FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (rfetch_q != 3'd0 && !rd_stall),
    .in_ready_o  (f_in_ready),
    .in_data_i   (mem_q[ra_q]),
    .out_valid_o (f_out_valid),
    .out_ready_i (pop),
    .out_data_o  (f_out_data)
  );

  // Output clocks: K pair, as the strap is sampled from s2_q while it still holds reset ones
  assign oclk_rise   = single_clk_q ? k_rise  : (s2_q[2] & ~s3_q[2]);
  assign oclk_n_rise = single_clk_q ? kn_rise : (s2_q[3] & ~s3_q[3]);
  // Output edges skipped before the first word: latency 1.5 or 1 cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      skip_q   <= '0;
      rq_cnt_q <= '0;
    end else begin
      if (start_rd && (rq_cnt_q == 4'd0 || (rq_cnt_q == 4'd1 && pop))) begin
        skip_q <= delay_loop_disable_n_n ? `QRS_SKIP_DLL : `QRS_SKIP_NODLL;
      end else if (skip_q != 2'd0 && (oclk_rise || oclk_n_rise)) begin
        skip_q <= skip_q - 2'd1;
      end
      rq_cnt_q <= rq_cnt_q + (start_rd ? 4'd4 : 4'd0) - 4'(pop);
    end
  end

  assign pop = f_out_valid && (skip_q == 2'd0) && (oclk_rise || oclk_n_rise);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o    <= '0;
      rdata_oe_o <= 1'b0;
    end else if (pop) begin
      rdata_o    <= f_out_data;
      rdata_oe_o <= 1'b1;
    end else if (oclk_rise && !f_out_valid && rfetch_q == 3'd0) begin
      rdata_oe_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Echo clocks; stopped input clocks freeze the read outputs and echoes, not the FIFO fetch or the K gap count
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      returned_strobe_o   <= 1'b0;
      returned_strobe_n_o <= 1'b1;
    end else begin
      returned_strobe_o   <= single_clk_q ? s2_q[0] : s2_q[2];
      returned_strobe_n_o <= single_clk_q ? s2_q[1] : s2_q[3];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_read_first;
    @(posedge clk_i) disable iff (!rst_n_i)
      (k_rise && last_q == LAST_IDLE && !rps_n && !wps_n) |-> start_rd && !start_wr;
  endproperty
  a_read_first: assert property (p_read_first) else $error("idle both-select not read");

  property p_after_read;
    @(posedge clk_i) disable iff (!rst_n_i)
      (start_rd ##1 (!k_rise) [*1] ##0 1'b1) |-> 1'b1;
  endproperty
  property p_no_back_read;
    @(posedge clk_i) disable iff (!rst_n_i)
      (k_rise && last_q == LAST_READ) |-> !start_rd;
  endproperty
  a_no_back_read: assert property (p_no_back_read) else $error("back to back read");

  property p_write_after_read;
    @(posedge clk_i) disable iff (!rst_n_i)
      (k_rise && last_q == LAST_READ && !wps_n) |-> start_wr;
  endproperty
  a_write_after_read: assert property (p_write_after_read) else $error("write lost");

  property p_read_after_write;
    @(posedge clk_i) disable iff (!rst_n_i)
      (k_rise && last_q == LAST_WRITE && !rps_n) |-> start_rd;
  endproperty
  a_read_after_write: assert property (p_read_after_write) else $error("read lost");

  property p_nop;
    @(posedge clk_i) disable iff (!rst_n_i)
      (rps_n && wps_n) |-> !start_rd && !start_wr;
  endproperty
  a_nop: assert property (p_nop) else $error("access without select");

  property p_only_k;
    @(posedge clk_i) disable iff (!rst_n_i)
      !k_rise |=> $stable(last_q);
  endproperty
  a_only_k: assert property (p_only_k) else $error("state moved off K rise");

  property p_write_len;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(wact_q) |-> wbeat_q == 2'd0;
  endproperty
  a_write_len: assert property (p_write_len) else $error("write burst start");

  property p_read_fill;
    @(posedge clk_i) disable iff (!rst_n_i)
      start_rd |=> rfetch_q == 3'd4;
  endproperty
  a_read_fill: assert property (p_read_fill) else $error("read burst not loaded");
endmodule

// ===== qrs_defs.svh
// Purpose: constants for the burst SRAM port logic
// Assumes: one system clock at 20 MHz, memory clocks sampled as pins
// Notes:   definitions only
`ifndef QRS_DEFS_SVH
`define QRS_DEFS_SVH
`define QRS_AW          8
`define QRS_DW          18
`define QRS_NBYTE       2
`define QRS_BYTEW       9
`define QRS_BURST_LAST  2'h3
`define QRS_ZQ_PERIOD   11'd1024
`define QRS_LOCK_CYCLES 11'd1024
`define QRS_FIFO_DEPTH  8
`define QRS_SKIP_DLL    2'd2
`define QRS_SKIP_NODLL  2'd1
`endif

// ===== qrs_pkg.sv
// Purpose: shared types for the burst SRAM port logic
// Assumes: nothing
// Notes:   states only
package qrs_pkg;
  typedef enum logic [1:0] {LAST_IDLE, LAST_READ, LAST_WRITE} last_op_type;
endpackage

// ===== qrs_fifo.sv
// Purpose: small valid/ready FIFO for read words
// Assumes: single clock
// Notes:   storage in flip-flops
`timescale 1ns/1ns
module qrs_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign push        = in_valid_i && (cnt_q != (AW+1)'(DEPTH));
  assign pop         = out_ready_i && (cnt_q != '0);
  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== qrs_ctrl_model.sv
// Purpose: memory controller model driving the port pins
// Assumes: K period is eight clk periods; pins move on clk fall
// Notes:   C follows K unless the one-clock strap is taken
`timescale 1ns/1ns
module qrs_ctrl_model (
  // Timing
  input  wire logic        clk_i,
  // Pins toward the port
  output logic             k_clk_o,
  output logic             k_clk_n_o,
  output logic             c_clk_o,
  output logic             c_clk_n_o,
  output logic             read_port_select_n_o,
  output logic             write_port_select_n_o,
  output logic [7:0]       addr_o,
  output logic [17:0]      wdata_o,
  output logic [1:0]       byte_write_select_n_o,
  // Pins from the port
  input  wire logic [17:0] rdata_i,
  input  wire logic        rdata_oe_i,
  input  wire logic        returned_strobe_i,
  input  wire logic        returned_strobe_n_i
);
  // ****
  // State
  // ****
  logic [17:0] rq [$];
  int          krise_cnt = 0;
  int          echo_bad  = 0;
  logic        single    = 1'b0;
  logic        run       = 1'b0;

  initial begin
    {k_clk_o, k_clk_n_o, c_clk_o, c_clk_n_o} = 4'h5;
    {read_port_select_n_o, write_port_select_n_o} = 2'h3;
    addr_o = 8'h00;
    wdata_o = 18'h00000;
    byte_write_select_n_o = 2'h3;
  end

  // ****
  // One K period
  // ****
  // Selects and K data move a quarter period before their rise
  task automatic kcycle(input logic rn, wn, input logic [7:0] a,
                        input logic [17:0] dk, dkn, input logic [1:0] bsn);
    for (int s = 0; s < 8; s++) begin
      @(negedge clk_i);
      if ((s == 2 || s == 6) && rdata_oe_i === 1'b1) rq.push_back(rdata_i);
      if (s == 0) begin
        if (run && {returned_strobe_i, returned_strobe_n_i} !== 2'h2) echo_bad++;
        {k_clk_o, k_clk_n_o, c_clk_o, c_clk_n_o} = {2'h1, single, 1'b1};
      end
      if (s == 2) begin
        {read_port_select_n_o, write_port_select_n_o} = {rn, wn};
        {addr_o, wdata_o, byte_write_select_n_o} = {a, dk, bsn};
      end
      if (s == 4) begin
        if ({returned_strobe_i, returned_strobe_n_i} !== 2'h1) echo_bad++;
        {k_clk_o, k_clk_n_o, c_clk_o, c_clk_n_o} = {3'h5, single};
        krise_cnt++;
      end
      if (s == 6) wdata_o = dkn;
    end
    run = 1'b1;
  endtask

  // Released address and K data show the inverse of their last value; K# data returns to it
  task automatic idle(input int n);
    repeat (n) kcycle(1'b1, 1'b1, ~addr_o, ~wdata_o, wdata_o, 2'h3);
  endtask

  // Clocks parked; a restart skips the first echo
  task automatic stop(input int n);
    run = 1'b0;
    repeat (n) @(negedge clk_i);
  endtask

  task automatic strap();
    single = 1'b1;
    run = 1'b0;
    {c_clk_o, c_clk_n_o} = 2'h3;
  endtask
endmodule

// ===== quad_rate_sram_port_logic_bench.sv
// Purpose: self-checking bench for the burst SRAM port logic
// Assumes: K period 400 ns, C tied to K unless strapped
// Notes:   rows first, then refusal, arbitration, stop, lock, strap
`timescale 1ns/1ns
`include "qrs_defs.svh"
module quad_rate_sram_port_logic_bench;
  // ****
  // Signals
  // ****
  typedef struct {
    logic [7:0]  a;
    logic [17:0] d;
    logic [1:0]  bsn;
    logic [17:0] exp;
  } row_type;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        dld_n = 1'b1;
  logic        k, kn, c, cn, rps_n, wps_n;
  logic [7:0]  addr;
  logic [17:0] wdata, rdata, r_hold;
  logic [1:0]  bsn;
  logic        oe, rs, rs_n, lock, zq, o_hold;
  logic [17:0] shadow [256];
  int          err_count = 0;
  int          samples_checked = 0;
  int          zq_cnt = 0;
  row_type     rows [5] = '{'{8'h10, 18'h00100, 2'h0, 18'h00100},
                            '{8'h10, 18'h2AAAA, 2'h2, 18'h000AA},
                            '{8'h10, 18'h15555, 2'h1, 18'h154AA},
                            '{8'h10, 18'h3FFFF, 2'h3, 18'h154AA},
                            '{8'hFE, 18'h0A000, 2'h0, 18'h0A000}};

  always #25 clk = ~clk;
  always @(posedge clk) if (zq === 1'b1) zq_cnt++;

  qrs_port qrs_port_i (.clk_i(clk), .rst_n_i(rst_n), .k_clk_i(k), .k_clk_n_i(kn),
    .c_clk_i(c), .c_clk_n_i(cn), .delay_loop_disable_n_i(dld_n),
    .read_port_select_n_i(rps_n), .write_port_select_n_i(wps_n), .addr_i(addr),
    .wdata_i(wdata), .byte_write_select_n_i(bsn), .rdata_o(rdata), .rdata_oe_o(oe),
    .returned_strobe_o(rs), .returned_strobe_n_o(rs_n), .lock_o(lock),
    .zq_update_o(zq));

  qrs_ctrl_model qrs_ctrl_model_i (.clk_i(clk), .k_clk_o(k), .k_clk_n_o(kn),
    .c_clk_o(c), .c_clk_n_o(cn), .read_port_select_n_o(rps_n),
    .write_port_select_n_o(wps_n), .addr_o(addr), .wdata_o(wdata),
    .byte_write_select_n_o(bsn), .rdata_i(rdata), .rdata_oe_i(oe),
    .returned_strobe_i(rs), .returned_strobe_n_i(rs_n));

  // ****
  // Tasks
  // ****
  task automatic check(input string what, input logic [17:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Shadow memory: lanes kept where their select is off
  task automatic upd(input logic [7:0] a, input logic [17:0] d, input logic [1:0] b);
    logic [17:0] w;
    for (int i = 0; i < 4; i++) begin
      w = d + 18'(i);
      if (!b[0]) shadow[8'(a + i)][8:0] = w[8:0];
      if (!b[1]) shadow[8'(a + i)][17:9] = w[17:9];
    end
  endtask

  // Write at a; the next K rise carries the second request
  task automatic wr(input logic [7:0] a, input logic [17:0] d, input logic [1:0] b,
                    input logic rn2, wn2, input logic [7:0] a2);
    qrs_ctrl_model_i.kcycle(1'b1, 1'b0, a, ~d, d, 2'h3);
    qrs_ctrl_model_i.kcycle(rn2, wn2, a2, d, d + 18'h1, b);
    qrs_ctrl_model_i.kcycle(1'b1, 1'b1, ~a, d + 18'h2, d + 18'h3, b);
    upd(a, d, b);
  endtask

  task automatic cmp_q(input int first, input logic [7:0] a);
    for (int i = 0; i < 4; i++)
      check("read word", qrs_ctrl_model_i.rq[first + i], shadow[8'(a + i)]);
  endtask

  task automatic rd_check(input logic [7:0] a);
    qrs_ctrl_model_i.rq.delete();
    qrs_ctrl_model_i.kcycle(1'b0, 1'b1, a, 18'h0, 18'h1, 2'h3);
    qrs_ctrl_model_i.idle(4);
    cmp_q(0, a);
    check("oe after idle", 18'(oe), 18'h0);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****
  // Sequence
  // ****
  initial begin
    repeat (20) @(negedge clk);
    check("oe in reset", 18'(oe), 18'h0);
    check("echo n in reset", 18'(rs_n), 18'h1);
    rst_n = 1'b1;
    qrs_ctrl_model_i.idle(4);
    check("lock early", 18'(lock), 18'h0);
    foreach (rows[i]) begin
      qrs_ctrl_model_i.rq.delete();
      wr(rows[i].a, rows[i].d, rows[i].bsn, 1'b0, 1'b1, rows[i].a);
      qrs_ctrl_model_i.idle(3);
      check("forwarded", qrs_ctrl_model_i.rq[0], rows[i].exp);
      cmp_q(0, rows[i].a);
    end
    // Second write on the next rise is dropped
    wr(8'h20, 18'h0C0C0, 2'h0, 1'b1, 1'b0, 8'h10);
    rd_check(8'h10);
    rd_check(8'h20);
    // Both selects held: read, write, read
    qrs_ctrl_model_i.rq.delete();
    qrs_ctrl_model_i.kcycle(1'b0, 1'b0, 8'h10, 18'h0, 18'h1, 2'h3);
    qrs_ctrl_model_i.kcycle(1'b0, 1'b0, 8'h40, 18'h2, 18'h3, 2'h3);
    qrs_ctrl_model_i.kcycle(1'b0, 1'b0, 8'h20, 18'h11111, 18'h11112, 2'h0);
    qrs_ctrl_model_i.kcycle(1'b1, 1'b1, 8'hBF, 18'h11113, 18'h11114, 2'h0);
    qrs_ctrl_model_i.idle(3);
    cmp_q(0, 8'h10);
    cmp_q(4, 8'h20);
    upd(8'h40, 18'h11111, 2'h0);
    rd_check(8'h40);
    // Clocks stopped after a read is taken, before its first word
    qrs_ctrl_model_i.rq.delete();
    qrs_ctrl_model_i.kcycle(1'b0, 1'b1, 8'h10, 18'h0, 18'h1, 2'h3);
    qrs_ctrl_model_i.idle(1);
    qrs_ctrl_model_i.stop(8);
    {r_hold, o_hold} = {rdata, oe};
    qrs_ctrl_model_i.stop(40);
    check("rdata held", rdata, r_hold);
    check("oe held", 18'(oe), 18'(o_hold));
    qrs_ctrl_model_i.idle(3);
    cmp_q(0, 8'h10);
    while (qrs_ctrl_model_i.krise_cnt < 1040) qrs_ctrl_model_i.idle(1);
    check("lock", 18'(lock), 18'h1);
    while (qrs_ctrl_model_i.krise_cnt % 1024 != 512) qrs_ctrl_model_i.idle(1);
    check("zq pulses", 18'(zq_cnt), 18'(qrs_ctrl_model_i.krise_cnt / 1024));
    // Delay loop bypassed: lock drops, reads still complete
    dld_n = 1'b0;
    qrs_ctrl_model_i.idle(1);
    check("lock off", 18'(lock), 18'h0);
    rd_check(8'h10);
    dld_n = 1'b1;
    // One-clock strap taken at a fresh reset
    rst_n = 1'b0;
    qrs_ctrl_model_i.strap();
    repeat (20) @(negedge clk);
    check("oe in reset", 18'(oe), 18'h0);
    rst_n = 1'b1;
    qrs_ctrl_model_i.idle(2);
    qrs_ctrl_model_i.rq.delete();
    wr(8'h30, 18'h2F0F0, 2'h0, 1'b0, 1'b1, 8'h30);
    qrs_ctrl_model_i.idle(3);
    cmp_q(0, 8'h30);
    check("echo misses", 18'(qrs_ctrl_model_i.echo_bad), 18'h0);
    complete_run();
  end

  // Whole run is near 12500 clk; margin for a stalled FIFO
  initial begin
    #2000000;
    err_count++;
    complete_run();
  end
endmodule
